// >>> hw/nfc_bus_cycle.sv
/*
 bus cycle engine: one asynchronous write or read to the flash pins.
 assumes data inputs settle within the read time; dq is sampled once.
*/
`timescale 1ns/1ps
module nfc_bus_cycle
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // sequencer side
   nfc_seq_if.eng cyc,
   // flash pins
   output logic [25:0] fl_addr_o,
   output logic [15:0] fl_dq_o,
   output logic fl_dq_oe_o,
   input wire logic [15:0] fl_dq_i,
   output logic fl_we_n_o,
   output logic fl_oe_n_o,
   output logic fl_ce_n_o
);
   typedef enum logic [1:0] {B_IDLE, B_ACT, B_REC} nfc_bstate_type;
   nfc_bstate_type st_q;
   logic [3:0] cnt_q;
   logic done_q;
   logic [15:0] rd_q;

   // ----------------------------------------------------------------
   // cycle timing
   // ----------------------------------------------------------------
   // recovery phase keeps we/oe high between cycles for the hold time
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= B_IDLE;
         cnt_q <= 4'h0;
         done_q <= 1'b0;
         rd_q <= 16'h0000;
         fl_addr_o <= 26'h0000000;
         fl_dq_o <= 16'h0000;
         fl_dq_oe_o <= 1'b0;
         fl_we_n_o <= 1'b1;
         fl_oe_n_o <= 1'b1;
         fl_ce_n_o <= 1'b1;
      end
      else
      begin
         done_q <= 1'b0;
         case (st_q)
            B_IDLE:
               if (cyc.req && !done_q)
               begin
                  st_q <= B_ACT;
                  fl_addr_o <= cyc.addr;
                  fl_dq_o <= cyc.wdata;
                  fl_dq_oe_o <= !cyc.is_read;
                  fl_ce_n_o <= 1'b0;
                  fl_we_n_o <= cyc.is_read;
                  fl_oe_n_o <= !cyc.is_read;
                  cnt_q <= cyc.is_read ? nfc_pkg::READ_CYC
                     : nfc_pkg::WE_LOW_CYC;
               end
            B_ACT:
               if (cnt_q == 4'h1)
               begin
                  st_q <= B_REC;
                  rd_q <= fl_dq_i;
                  fl_we_n_o <= 1'b1;
                  fl_oe_n_o <= 1'b1;
                  cnt_q <= nfc_pkg::WE_HIGH_CYC;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
            default:
               if (cnt_q == 4'h1)
               begin
                  st_q <= B_IDLE;
                  fl_ce_n_o <= 1'b1;
                  fl_dq_oe_o <= 1'b0;
                  done_q <= 1'b1;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
         endcase
      end
   end

   assign cyc.done = done_q;
   assign cyc.rdata = rd_q;
endmodule

// >>> hw/nfc_ctrl.sv
/*
 host controller for the erase side of a parallel nor flash: issues
 bypass block erase, suspend/resume, chip erase and blank check, polls
 the status register and drives the write-protect/accelerate pins.
 assumes the flash sits on its pins, unclocked, and a 50 MHz clock.
*/
`timescale 1ns/1ps
module nfc_ctrl
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // user command port
   input wire logic op_valid_i,
   input wire nfc_pkg::nfc_op_type op_code_i,
   input wire logic [25:0] op_addr_i,
   input wire logic accel_i,
   input wire logic edge_protect_i,
   output logic op_ready_o,
   output logic op_done_o,
   output logic op_fail_o,
   output logic suspended_o,
   output logic erase_timer_status_bit_o,
   output logic [15:0] status_o,
   // flash pins
   output logic [25:0] fl_addr_o,
   output logic [15:0] fl_dq_o,
   output logic fl_dq_oe_o,
   input wire logic [15:0] fl_dq_i,
   output logic fl_we_n_o,
   output logic fl_oe_n_o,
   output logic fl_ce_n_o,
   output logic fl_wp_n_o,
   output logic high_voltage_accel_level_o
);
   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_POLL, S_FAILED}
      nfc_state_type;
   nfc_state_type st_q;
   nfc_pkg::nfc_op_type op_q;
   logic [1:0] idx_q;
   logic [1:0] last_q;
   logic [25:0] blk_q;
   logic bypass_q;
   logic susp_q;
   logic chip_q;
   logic first_poll_q;
   logic [15:0] prev_q;
   logic [2:0] dq_m_q;
   logic wait_cyc_q;
   logic [15:0] rd_s1_q;
   logic [15:0] rd_s2_q;
   nfc_seq_if cyc ();

   // ----------------------------------------------------------------
   // command table
   // ----------------------------------------------------------------
   // returns address and data of cycle i of an operation
   function automatic logic [41:0] cmd_cycle(input nfc_pkg::nfc_op_type o,
      input logic [1:0] i, input logic [25:0] a);
      logic [41:0] r;
      r = {a, nfc_pkg::CMD_READ_RESET};
      case (o)
         nfc_pkg::OP_BLOCK_ERASE:
            r = (i == 2'd0) ? {a, nfc_pkg::CMD_ERASE_SETUP}
               : {a, nfc_pkg::CMD_BLOCK_ERASE};
         nfc_pkg::OP_ADD_BLOCK: r = {a, nfc_pkg::CMD_BLOCK_ERASE};
         nfc_pkg::OP_SUSPEND: r = {a, nfc_pkg::CMD_SUSPEND};
         nfc_pkg::OP_RESUME: r = {a, nfc_pkg::CMD_RESUME};
         nfc_pkg::OP_CHIP_ERASE:
            r = (i == 2'd0) ? {a, nfc_pkg::CMD_ERASE_SETUP}
               : {a, nfc_pkg::CMD_CHIP_ERASE};
         nfc_pkg::OP_BLANK_CHECK:
            r = (i == 2'd0) ? {nfc_pkg::UNLOCK_ADDR1, nfc_pkg::UNLOCK_DATA1}
               : (i == 2'd1) ? {nfc_pkg::UNLOCK_ADDR2, nfc_pkg::UNLOCK_DATA2}
               : (i == 2'd2) ? {a, nfc_pkg::CMD_BLANK_SETUP1}
               : {a, nfc_pkg::CMD_BLANK_CONFIRM};
         nfc_pkg::OP_BYPASS_EXIT:
            r = (i == 2'd0) ? {a, nfc_pkg::CMD_BYPASS_EXIT1}
               : {a, nfc_pkg::CMD_BYPASS_EXIT2};
         default: r = {a, nfc_pkg::CMD_READ_RESET};
      endcase
      return r;
   endfunction

   // number of write cycles minus one for an operation
   function automatic logic [1:0] cmd_len(input nfc_pkg::nfc_op_type o,
      input logic byp);
      logic [1:0] n;
      n = 2'd0;
      case (o)
         nfc_pkg::OP_BLOCK_ERASE: n = 2'd1;
         nfc_pkg::OP_CHIP_ERASE: n = 2'd1;
         nfc_pkg::OP_BLANK_CHECK: n = 2'd3;
         nfc_pkg::OP_BYPASS_EXIT: n = 2'd1;
         default: n = 2'd0;
      endcase
      if (!byp && (o == nfc_pkg::OP_BLOCK_ERASE
         || o == nfc_pkg::OP_CHIP_ERASE))
         n = 2'd1;
      return n;
   endfunction

   // ----------------------------------------------------------------
   // pin sampling and wp pins
   // ----------------------------------------------------------------
   // two stage sampler; rdata already registered by the engine but
   // dq comes from an unclocked part, so it is re-sampled here
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rd_s1_q <= 16'h0000;
         rd_s2_q <= 16'h0000;
      end
      else
      begin
         rd_s1_q <= cyc.rdata;
         rd_s2_q <= rd_s1_q;
      end
   end

   // accel forces wp high voltage; edge protect pulls wp low
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         fl_wp_n_o <= 1'b0;
         high_voltage_accel_level_o <= 1'b0;
      end
      else if (st_q == S_IDLE)
      begin
         fl_wp_n_o <= !edge_protect_i;
         high_voltage_accel_level_o <= accel_i;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   wire issue = op_valid_i && op_ready_o;
   wire [41:0] cur = cmd_cycle(op_q, idx_q, blk_q);
   // a read completes after the engine's done plus the two-stage resample
   wire toggled = (rd_s2_q[nfc_pkg::POLL_TOGGLE_BIT] !=
      prev_q[nfc_pkg::POLL_TOGGLE_BIT]);

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= S_IDLE;
         op_q <= nfc_pkg::OP_READ_RESET;
         idx_q <= 2'd0;
         last_q <= 2'd0;
         blk_q <= 26'h0000000;
         bypass_q <= 1'b0;
         susp_q <= 1'b0;
         chip_q <= 1'b0;
         first_poll_q <= 1'b0;
         prev_q <= 16'h0000;
         dq_m_q <= 3'd0;
         wait_cyc_q <= 1'b0;
         op_done_o <= 1'b0;
         op_fail_o <= 1'b0;
         erase_timer_status_bit_o <= 1'b0;
         status_o <= 16'h0000;
      end
      else
      begin
         op_done_o <= 1'b0;
         case (st_q)
            S_IDLE:
               if (issue)
               begin
                  op_q <= op_code_i;
                  blk_q <= op_addr_i;
                  idx_q <= 2'd0;
                  last_q <= cmd_len(op_code_i, bypass_q || accel_i);
                  bypass_q <= bypass_q || accel_i;
                  st_q <= S_WRITE;
                  wait_cyc_q <= 1'b0;
               end
            S_WRITE:
               if (cyc.done)
               begin
                  if (idx_q != last_q)
                     idx_q <= idx_q + 2'd1;
                  else
                  begin
                     case (op_q)
                        nfc_pkg::OP_SUSPEND: susp_q <= !chip_q;
                        nfc_pkg::OP_RESUME: susp_q <= 1'b0;
                        nfc_pkg::OP_BYPASS_EXIT: bypass_q <= 1'b0;
                        nfc_pkg::OP_READ_RESET: op_fail_o <= 1'b0;
                        nfc_pkg::OP_CHIP_ERASE: chip_q <= 1'b1;
                        default: chip_q <= chip_q;
                     endcase
                     // block erase is not polled: added blocks and a
                     // suspend must still land inside its window
                     if (op_q == nfc_pkg::OP_CHIP_ERASE
                        || op_q == nfc_pkg::OP_BLANK_CHECK
                        || op_q == nfc_pkg::OP_RESUME)
                     begin
                        st_q <= S_POLL;
                        first_poll_q <= 1'b1;
                        dq_m_q <= 3'd0;
                     end
                     else
                     begin
                        st_q <= S_IDLE;
                        op_done_o <= 1'b1;
                     end
                  end
               end
            S_POLL:
               if (cyc.done)
                  wait_cyc_q <= 1'b1;
               else if (wait_cyc_q)
               begin
                  dq_m_q <= dq_m_q + 3'd1;
                  if (dq_m_q == 3'd1)
                  begin
                     wait_cyc_q <= 1'b0;
                     dq_m_q <= 3'd0;
                     prev_q <= rd_s2_q;
                     status_o <= rd_s2_q;
                     first_poll_q <= 1'b0;
                     erase_timer_status_bit_o <=
                        rd_s2_q[nfc_pkg::POLL_TIMER_BIT];
                     if (!first_poll_q && !toggled)
                     begin
                        st_q <= S_IDLE;
                        op_done_o <= 1'b1;
                        chip_q <= 1'b0;
                     end
                     else if (!first_poll_q &&
                        rd_s2_q[nfc_pkg::POLL_FAIL_BIT])
                     begin
                        st_q <= S_FAILED;
                        op_fail_o <= 1'b1;
                        chip_q <= 1'b0;
                     end
                  end
               end
            default:
               begin
                  // the device holds polling output until read/reset
                  // op_fail_o stays up for a blank check and re-erase
                  st_q <= S_IDLE;
                  op_done_o <= 1'b1;
               end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // cycle requests
   // ----------------------------------------------------------------
   // ready only while idle; a resume polls a block erase to its end
   assign op_ready_o = (st_q == S_IDLE);
   assign suspended_o = susp_q;
   assign cyc.req = (st_q == S_WRITE) || (st_q == S_POLL && !wait_cyc_q
      && dq_m_q == 3'd0);
   assign cyc.is_read = (st_q == S_POLL);
   assign cyc.addr = (st_q == S_POLL) ? blk_q : cur[41:16];
   assign cyc.wdata = cur[15:0];

   nfc_bus_cycle u_bus
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .cyc(cyc),
      .fl_addr_o(fl_addr_o),
      .fl_dq_o(fl_dq_o),
      .fl_dq_oe_o(fl_dq_oe_o),
      .fl_dq_i(fl_dq_i),
      .fl_we_n_o(fl_we_n_o),
      .fl_oe_n_o(fl_oe_n_o),
      .fl_ce_n_o(fl_ce_n_o)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_two_write_erase;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (issue && op_code_i == nfc_pkg::OP_BLOCK_ERASE) |=> last_q == 2'd1;
   endproperty
   a_two_write_erase: assert property (p_two_write_erase)
      else $error("bypass block erase not two writes");
   property p_no_susp_chip;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_WRITE && op_q == nfc_pkg::OP_SUSPEND && chip_q
         && cyc.done && idx_q == last_q) |=> !susp_q;
   endproperty
   a_no_susp_chip: assert property (p_no_susp_chip)
      else $error("suspend marked during chip erase");
   property p_resume_clears;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_WRITE && op_q == nfc_pkg::OP_RESUME && cyc.done)
         |=> !susp_q && st_q == S_POLL;
   endproperty
   a_resume_clears: assert property (p_resume_clears)
      else $error("resume did not clear suspend");
   property p_poll_reads;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_POLL && cyc.req) |-> cyc.is_read;
   endproperty
   a_poll_reads: assert property (p_poll_reads)
      else $error("write issued while polling");
   property p_fail_flag;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_FAILED) |-> op_fail_o ##1 op_done_o;
   endproperty
   a_fail_flag: assert property (p_fail_flag)
      else $error("fail not reported");
   property p_wp_pin;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_IDLE && edge_protect_i) |=> !fl_wp_n_o;
   endproperty
   a_wp_pin: assert property (p_wp_pin)
      else $error("write protect pin not low");
   property p_accel;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (issue && accel_i) |=> bypass_q;
   endproperty
   a_accel: assert property (p_accel)
      else $error("accel did not set bypass");
   property p_suspend_code;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_q == S_WRITE && op_q == nfc_pkg::OP_SUSPEND)
         |-> cyc.wdata == nfc_pkg::CMD_SUSPEND;
   endproperty
   a_suspend_code: assert property (p_suspend_code)
      else $error("wrong suspend code");
   c_erase: cover property (@(posedge clk_sys_i)
      issue && op_code_i == nfc_pkg::OP_BLOCK_ERASE);
   c_fail: cover property (@(posedge clk_sys_i) st_q == S_FAILED);
   c_susp: cover property (@(posedge clk_sys_i) susp_q);
endmodule

// >>> hw/nfc_pkg.sv
/*
 package for the host-side flash erase controller: command codes,
 addresses, polling bit positions and timing counts.
 assumes a 50 MHz system clock.
*/
package nfc_pkg;
   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   // ----------------------------------------------------------------
   // command cycles (address, data)
   // ----------------------------------------------------------------
   localparam logic [25:0] UNLOCK_ADDR1 = 26'h0000555;
   localparam logic [25:0] UNLOCK_ADDR2 = 26'h00002AA;
   localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
   localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
   localparam logic [15:0] CMD_BYPASS_ENTER = 16'h0020;
   localparam logic [15:0] CMD_BYPASS_EXIT1 = 16'h0090;
   localparam logic [15:0] CMD_BYPASS_EXIT2 = 16'h0000;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0030;
   localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
   localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] CMD_BLANK_SETUP1 = 16'h00EB;
   localparam logic [15:0] CMD_BLANK_SETUP2 = 16'h0076;
   localparam logic [15:0] CMD_BLANK_CONFIRM = 16'h0029;
   localparam logic [15:0] CMD_READ_RESET = 16'h00F0;
   // ----------------------------------------------------------------
   // polling register bits
   // ----------------------------------------------------------------
   localparam int POLL_TOGGLE_BIT = 6;
   localparam int POLL_FAIL_BIT = 5;
   localparam int POLL_TIMER_BIT = 3;
   // ----------------------------------------------------------------
   // bus timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_WE_LOW_NS = 50;
   localparam int T_WE_HIGH_NS = 30;
   localparam int T_READ_NS = 100;
   localparam logic [3:0] WE_LOW_CYC =
      4'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WE_HIGH_CYC =
      4'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] READ_CYC =
      4'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ----------------------------------------------------------------
   // user operations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_BLOCK_ERASE, OP_ADD_BLOCK, OP_SUSPEND, OP_RESUME,
      OP_CHIP_ERASE, OP_BLANK_CHECK, OP_READ_RESET, OP_BYPASS_EXIT
   } nfc_op_type;
   localparam int MAX_CYCLES = 4;
endpackage

// >>> hw/nfc_seq_if.sv
/*
 interface between the command sequencer and the bus cycle engine.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface nfc_seq_if;
   logic req;
   logic is_read;
   logic [25:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport seq (output req, output is_read, output addr, output wdata,
      input done, input rdata);
   modport eng (input req, input is_read, input addr, input wdata,
      output done, output rdata);
endinterface

// >>> test/nfc_ctrl_bench.sv
/*
 self-checking bench for the erase controller against the flash model.
 assumes the controller's user port contract and a 50 MHz clock.
*/
`timescale 1ns/1ps
module nfc_ctrl_bench;
   logic clk_sys_i = 0;
   logic reset_n_i = 0;
   logic op_valid_i = 0;
   nfc_pkg::nfc_op_type op_code_i = nfc_pkg::OP_READ_RESET;
   logic [25:0] op_addr_i = 26'h0000000;
   logic accel_i = 0;
   logic edge_protect_i = 0;
   logic op_ready_o, op_done_o, op_fail_o, suspended_o;
   logic erase_timer_status_bit_o, fl_dq_oe_o, high_voltage_accel_level_o;
   logic fl_we_n_o, fl_oe_n_o, fl_ce_n_o, fl_wp_n_o;
   logic [15:0] status_o, fl_dq_o, fl_dq_i, mdl_dq;
   logic [25:0] fl_addr_o;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int i;
   // ----------------------------------------------------------------
   // clock, wiring and instances
   // ----------------------------------------------------------------
   always #10 clk_sys_i = ~clk_sys_i;
   assign fl_dq_i = fl_dq_oe_o ? fl_dq_o : mdl_dq;
   nfc_ctrl dut (.clk_sys_i, .reset_n_i, .op_valid_i, .op_code_i,
      .op_addr_i, .accel_i, .edge_protect_i, .op_ready_o, .op_done_o,
      .op_fail_o, .suspended_o, .erase_timer_status_bit_o, .status_o,
      .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i, .fl_we_n_o, .fl_oe_n_o,
      .fl_ce_n_o, .fl_wp_n_o, .high_voltage_accel_level_o);
   nfc_flash_model #(.BAD_BLK(5), .DIRTY_BLK(3)) mdl (.addr_i(fl_addr_o),
      .wdata_i(fl_dq_o), .rdata_o(mdl_dq), .we_n_i(fl_we_n_o),
      .oe_n_i(fl_oe_n_o), .ce_n_i(fl_ce_n_o), .wp_n_i(fl_wp_n_o),
      .hv_i(high_voltage_accel_level_o));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // request held until taken, then wait for the done pulse
   task automatic do_op(input nfc_pkg::nfc_op_type c, input logic [25:0] a);
      int n;
      @(negedge clk_sys_i);
      op_valid_i = 1;
      op_code_i = c;
      op_addr_i = a;
      // ready is looked at while settled; the next rising edge takes it
      while (op_ready_o !== 1'b1)
         @(negedge clk_sys_i);
      @(negedge clk_sys_i);
      op_valid_i = 0;
      n = 0;
      while (op_done_o !== 1'b1 && n < 5000)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(n < 5000, 1'b1, "operation never finished");
   endtask
   // hang guard: the whole run needs far fewer cycles
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (12) @(negedge clk_sys_i);
      chk(fl_we_n_o, 1'b1, "write strobe active in reset");
      reset_n_i = 1;
      do_op(nfc_pkg::OP_BLOCK_ERASE, 26'h0010000);
      do_op(nfc_pkg::OP_ADD_BLOCK, 26'h0020000);
      chk(mdl.n_blocks == 2, 1'b1, "erase list length");
      for (i = 0; i < 2; i++)
      begin
         do_op(nfc_pkg::OP_SUSPEND, 26'h0000000);
         chk(suspended_o, 1'b1, "not suspended");
         chk(mdl.susp, i == 0, "flash not suspended");
         do_op(nfc_pkg::OP_RESUME, 26'h0000000);
         chk(suspended_o, 1'b0, "still suspended");
         chk(mdl.susp, 1'b0, "flash still suspended");
         chk(erase_timer_status_bit_o, 1'b1, "timer bit low");
      end
      i = 0;
      while (mdl.busy > 0 && i < 2000)
      begin
         @(negedge clk_sys_i);
         i++;
      end
      accel_i = 1;
      do_op(nfc_pkg::OP_CHIP_ERASE, 26'h0000000);
      chk(op_fail_o, 1'b1, "chip erase fail lost");
      chk(status_o[nfc_pkg::POLL_FAIL_BIT], 1'b1, "status fail bit");
      accel_i = 0;
      do_op(nfc_pkg::OP_READ_RESET, 26'h0000000);
      chk(op_fail_o, 1'b0, "fail not cleared");
      for (i = 0; i < 2; i++)
      begin
         do_op(nfc_pkg::OP_BLANK_CHECK, 26'((i + 3) << 16));
         chk(op_fail_o, i == 0, "blank check result");
         do_op(nfc_pkg::OP_READ_RESET, 26'h0000000);
      end
      edge_protect_i = 1;
      do_op(nfc_pkg::OP_BLOCK_ERASE, 26'h0000000);
      chk(fl_wp_n_o, 1'b0, "protect pin not low");
      chk(mdl.n_blocks == 2, 1'b1, "protected block erased");
      edge_protect_i = 0;
      do_op(nfc_pkg::OP_BYPASS_EXIT, 26'h0000000);
      chk(fl_wp_n_o, 1'b1, "protect pin not released");
      end_of_test();
   end
endmodule

// >>> test/nfc_flash_model.sv
/*
 behavioural erase-side model of the parallel nor flash on the host pins.
 assumes one write per rising write strobe and reads by oe_n low.
*/
`timescale 1ns/1ps
module nfc_flash_model
#(
   parameter int BAD_BLK = 5,
   parameter int DIRTY_BLK = 3
)
(
   // host bus
   input wire logic [25:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic ce_n_i,
   // protect pins
   input wire logic wp_n_i,
   input wire logic hv_i
);
   int mode = 0;
   int win = 0;
   int busy = 0;
   int n_blocks = 0;
   int blk = 0;
   logic setup = 0;
   logic bsetup = 0;
   logic susp = 0;
   logic fail = 0;
   logic pend = 0;
   int eblk = -1;
   logic tog = 0;
   logic byp = 0;
   logic [15:0] poll;
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   // decode on the strobe's rising edge; busy time counts in ticks
   always @(posedge we_n_i)
   begin
      blk = int'(addr_i[25:16]);
      if (!ce_n_i && busy > 0 && !susp)
      begin
         if (wdata_i == 16'h00B0 && mode == 1)
            susp = 1;
         else if (wdata_i == 16'h0030 && win > 0 && mode == 1)
         begin
            n_blocks++;
            win = 2;
         end
         else if (wdata_i == 16'h00F0 && win > 0)
            busy = 0;
      end // anything else is ignored
      else if (!ce_n_i)
      begin
         case (wdata_i)
            16'h0020: byp = 1;
            16'h0090: byp = 0;
            16'h0030:
               // no software protection is set up: default mode
               if (setup && !(blk == 0 && !wp_n_i))
               begin
                  mode = 1;
                  n_blocks++;
                  win = 2;
                  eblk = blk;
                  pend = 0;
                  // a blank block skips the erase itself
                  busy = (blk == DIRTY_BLK) ? 4 : 1;
               end
               else if (susp)
                  susp = 0;
            16'h0010:
               if (setup && (byp || hv_i))
               begin
                  mode = 2;
                  busy = 4;
                  fail = 0;
                  pend = (BAD_BLK >= 0);
               end
            16'h0029:
               if (bsetup)
               begin
                  mode = 3;
                  busy = 2;
                  fail = 0;
                  pend = (blk == DIRTY_BLK);
               end
            16'h00F0: fail = 0;
            default: ; // programs are never applied
         endcase
         setup = (wdata_i == 16'h0080);
         bsetup = (wdata_i == 16'h00EB);
      end
   end
   // time passes only while the erase is not suspended
   // the outcome of an erase or check shows only when it finishes
   always #400
      if (!susp)
      begin
         if (win > 0)
            win--;
         else if (busy > 0)
         begin
            busy--;
            if (busy == 0)
               fail = pend;
         end
      end
   // every polled read flips the toggle bit while busy and not suspended, or in error
   always @(posedge oe_n_i)
      if ((busy > 0 && !susp) || fail)
         tog = ~tog;
   // released bus shows a moving pattern, never the last value
   assign poll = {9'h000, tog, fail, 1'b0, win == 0, 3'h0};
   assign rdata_o = (oe_n_i || ce_n_i) ? (16'h5A5A ^ {16{tog}}) :
      (((busy > 0 && !susp) || fail) ? poll :
      (susp && int'(addr_i[25:16]) == eblk) ? poll :
      16'hFFFF);
endmodule
